// File: design/mcg_cal.sv
// Contract
// - voltage and current gains are 2.14 multipliers, 0x4000 is unity
// - reactive energy is signed; top bit set means capacitive
// - reactive over active energy equals tangent of power angle
// - phase offsets are signed radians times 65,536; capacitive positive
// - three offsets chosen by two current thresholds; zero gives first
// - separate power gain scales power and energy after v and i gains
// - active energy at 0x1d0, reactive energy at 0x1d4, readable
// - rms readings have lsb of full scale over 2^24
module mcg_cal (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // samples from the converter side
  input wire logic sample_valid_in,
  input wire logic signed [23:0] volt_sample_in,
  input wire logic signed [23:0] volt_quad_in,
  input wire logic signed [23:0] curr_sample_in,
  // rms readings from the rms engine, fed by the corrected samples
  input wire logic [23:0] voltage_rms_reading_in,
  input wire logic [23:0] current_rms_reading_in,
  // register port
  input wire logic [11:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // corrected samples toward rms engine
  output logic corr_valid_out,
  output logic signed [23:0] corr_volt_out,
  output logic signed [23:0] corr_curr_out
);
  // ==========================================================
  // helpers
  function automatic logic signed [23:0] apply_gain(
    input logic signed [23:0] x, input logic [15:0] g);
    logic signed [40:0] pr;
    pr = x * $signed({1'b0, g});
    return pr[mcg_pkg::GAIN_FRAC +: mcg_pkg::SAMPLE_W];
  endfunction : apply_gain

  function automatic logic signed [23:0] hi_product(
    input logic signed [23:0] a, input logic signed [23:0] b);
    logic signed [47:0] pr;
    pr = a * b;
    return pr[mcg_pkg::SAMPLE_W +: mcg_pkg::SAMPLE_W];
  endfunction : hi_product

  // ==========================================================
  // calibration registers
  logic [15:0] volt_gain, curr_gain, power_gain;
  logic [15:0] offset_first, offset_second, offset_third;
  logic [15:0] thr_low, thr_high;
  logic [15:0] next_volt_gain, next_curr_gain, next_power_gain;
  logic [15:0] next_offset_first, next_offset_second, next_offset_third;
  logic [15:0] next_thr_low, next_thr_high;
  logic [31:0] next_rdata;
  logic next_rvalid;
  logic [47:0] act_acc, rea_acc, next_act_acc, next_rea_acc;
  logic [31:0] active_energy, reactive_energy;

  assign active_energy = act_acc[mcg_pkg::ACC_LSB +: mcg_pkg::DATA_W];
  assign reactive_energy = rea_acc[mcg_pkg::ACC_LSB +: mcg_pkg::DATA_W];

  // writes store, reads answer one cycle later; unmapped reads give zero
  always_comb begin
    next_volt_gain = volt_gain;
    next_curr_gain = curr_gain;
    next_power_gain = power_gain;
    next_offset_first = offset_first;
    next_offset_second = offset_second;
    next_offset_third = offset_third;
    next_thr_low = thr_low;
    next_thr_high = thr_high;
    if (reg_wr_in) begin
      case (reg_addr_in)
        mcg_pkg::VOLT_GAIN_ADDR: next_volt_gain = reg_wdata_in[15:0];
        mcg_pkg::CURR_GAIN_ADDR: next_curr_gain = reg_wdata_in[15:0];
        mcg_pkg::POWER_GAIN_ADDR: next_power_gain = reg_wdata_in[15:0];
        mcg_pkg::OFFSET_FIRST_ADDR: next_offset_first = reg_wdata_in[15:0];
        mcg_pkg::OFFSET_SECOND_ADDR: next_offset_second = reg_wdata_in[15:0];
        mcg_pkg::OFFSET_THIRD_ADDR: next_offset_third = reg_wdata_in[15:0];
        mcg_pkg::THR_LOW_ADDR: next_thr_low = reg_wdata_in[15:0];
        mcg_pkg::THR_HIGH_ADDR: next_thr_high = reg_wdata_in[15:0];
        default: ;
      endcase
    end
    next_rvalid = reg_rd_in;
    next_rdata = 32'h0000_0000;
    if (reg_rd_in) begin
      case (reg_addr_in)
        mcg_pkg::VOLT_GAIN_ADDR: next_rdata = {16'h0000, volt_gain};
        mcg_pkg::CURR_GAIN_ADDR: next_rdata = {16'h0000, curr_gain};
        mcg_pkg::POWER_GAIN_ADDR: next_rdata = {16'h0000, power_gain};
        mcg_pkg::OFFSET_FIRST_ADDR: next_rdata = {16'h0000, offset_first};
        mcg_pkg::OFFSET_SECOND_ADDR: next_rdata = {16'h0000, offset_second};
        mcg_pkg::OFFSET_THIRD_ADDR: next_rdata = {16'h0000, offset_third};
        mcg_pkg::THR_LOW_ADDR: next_rdata = {16'h0000, thr_low};
        mcg_pkg::THR_HIGH_ADDR: next_rdata = {16'h0000, thr_high};
        // rms words keep their 2^24 full-scale lsb
        mcg_pkg::VOLT_RMS_ADDR:
          next_rdata = {8'h00, voltage_rms_reading_in};
        mcg_pkg::CURR_RMS_ADDR:
          next_rdata = {8'h00, current_rms_reading_in};
        mcg_pkg::ACTIVE_ENERGY_ADDR: next_rdata = active_energy;
        mcg_pkg::REACTIVE_ENERGY_ADDR:
          next_rdata = reactive_energy;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // nothing survives reset: the host reloads the three gains
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      volt_gain <= mcg_pkg::GAIN_UNITY;
      curr_gain <= mcg_pkg::GAIN_UNITY;
      power_gain <= mcg_pkg::GAIN_UNITY;
      offset_first <= mcg_pkg::OFFSET_RST;
      offset_second <= mcg_pkg::OFFSET_RST;
      offset_third <= mcg_pkg::OFFSET_RST;
      thr_low <= mcg_pkg::THR_RST;
      thr_high <= mcg_pkg::THR_RST;
      reg_rdata_out <= 32'h0000_0000;
      reg_rvalid_out <= 1'b0;
    end else begin
      volt_gain <= next_volt_gain;
      curr_gain <= next_curr_gain;
      power_gain <= next_power_gain;
      offset_first <= next_offset_first;
      offset_second <= next_offset_second;
      offset_third <= next_offset_third;
      thr_low <= next_thr_low;
      thr_high <= next_thr_high;
      reg_rdata_out <= next_rdata;
      reg_rvalid_out <= next_rvalid;
    end
  end

  // ==========================================================
  // offset selection by current level
  logic [15:0] curr_level;
  logic signed [15:0] offset_sel;
  assign curr_level = current_rms_reading_in[mcg_pkg::THR_LSB +: 16];

  // a zero threshold is disabled, so defaults keep the first offset
  always_comb begin
    offset_sel = offset_first;
    if (thr_low != mcg_pkg::THR_RST && curr_level >= thr_low) begin
      offset_sel = offset_second;
      if (thr_high != mcg_pkg::THR_RST && curr_level >= thr_high) begin
        offset_sel = offset_third;
      end
    end
  end

  // ==========================================================
  // datapath: gain, products, phase and power gain, accumulate
  logic s1_valid, s2_valid, next_s1_valid, next_s2_valid;
  logic signed [23:0] s1_quad, next_s1_quad, next_corr_v, next_corr_i;
  logic signed [23:0] s2_p, s2_q, next_s2_p, next_s2_q;
  logic signed [39:0] rot_p, rot_q;
  logic signed [23:0] p_rot, q_rot;
  logic signed [23:0] p_gain, q_gain;

  // small-angle rotation: positive offset moves toward capacitive
  always_comb begin
    rot_p = s2_q * offset_sel;
    rot_q = s2_p * offset_sel;
    p_rot = s2_p + rot_p[mcg_pkg::ANGLE_FRAC +: 24];
    q_rot = s2_q - rot_q[mcg_pkg::ANGLE_FRAC +: 24];
    // power gain on top of the v and i gains already in the products
    p_gain = apply_gain(p_rot, power_gain);
    q_gain = apply_gain(q_rot, power_gain);
  end

  always_comb begin
    next_s1_valid = sample_valid_in;
    next_corr_v = corr_volt_out;
    next_corr_i = corr_curr_out;
    next_s1_quad = s1_quad;
    if (sample_valid_in) begin
      next_corr_v = apply_gain(volt_sample_in, volt_gain);
      next_corr_i = apply_gain(curr_sample_in, curr_gain);
      next_s1_quad = apply_gain(volt_quad_in, volt_gain);
    end
    next_s2_valid = s1_valid;
    next_s2_p = s2_p;
    next_s2_q = s2_q;
    if (s1_valid) begin
      // in-phase and quadrature products give p and q, so q/p = tan
      next_s2_p = hi_product(corr_volt_out, corr_curr_out);
      next_s2_q = hi_product(s1_quad, corr_curr_out);
    end
    next_act_acc = act_acc;
    next_rea_acc = rea_acc;
    if (s2_valid) begin
      // both sums share one power gain so their ratio stays tan
      next_act_acc = act_acc + {{24{p_gain[23]}}, p_gain};
      next_rea_acc = rea_acc + {{24{q_gain[23]}}, q_gain};
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      s1_valid <= 1'b0;
      s2_valid <= 1'b0;
      corr_valid_out <= 1'b0;
      corr_volt_out <= 24'sh000000;
      corr_curr_out <= 24'sh000000;
      s1_quad <= 24'sh000000;
      s2_p <= 24'sh000000;
      s2_q <= 24'sh000000;
      act_acc <= 48'h0000_0000_0000;
      rea_acc <= 48'h0000_0000_0000;
    end else begin
      s1_valid <= next_s1_valid;
      s2_valid <= next_s2_valid;
      corr_valid_out <= next_s1_valid;
      corr_volt_out <= next_corr_v;
      corr_curr_out <= next_corr_i;
      s1_quad <= next_s1_quad;
      s2_p <= next_s2_p;
      s2_q <= next_s2_q;
      act_acc <= next_act_acc;
      rea_acc <= next_rea_acc;
    end
  end

  // ==========================================================
  // assertions
  unity_gain_a: assert property (@(posedge clock_in)
    disable iff (!rst_b_in)
    sample_valid_in && volt_gain == mcg_pkg::GAIN_UNITY |=>
    corr_volt_out == $past(volt_sample_in))
    else $error("unity voltage gain altered the sample");
  gain_math_a: assert property (@(posedge clock_in)
    disable iff (!rst_b_in)
    sample_valid_in && curr_gain == 16'h8000 &&
    curr_sample_in == 24'sh000100 |=> corr_curr_out == 24'sh000200)
    else $error("current gain shift is wrong");
  gain_reset_a: assert property (@(posedge clock_in)
    !rst_b_in |=> volt_gain == mcg_pkg::GAIN_UNITY &&
    curr_gain == mcg_pkg::GAIN_UNITY)
    else $error("gains not unity after reset");
  offset_default_a: assert property (@(posedge clock_in)
    disable iff (!rst_b_in)
    thr_low == mcg_pkg::THR_RST && thr_high == mcg_pkg::THR_RST |->
    offset_sel == offset_first)
    else $error("default thresholds did not pick first offset");
  offset_third_a: assert property (@(posedge clock_in)
    disable iff (!rst_b_in)
    thr_low != mcg_pkg::THR_RST && thr_high != mcg_pkg::THR_RST &&
    curr_level >= thr_low && curr_level >= thr_high |->
    offset_sel == offset_third)
    else $error("high current did not pick third offset");
  active_read_a: assert property (@(posedge clock_in)
    disable iff (!rst_b_in)
    reg_rd_in && reg_addr_in == mcg_pkg::ACTIVE_ENERGY_ADDR |=>
    reg_rvalid_out && reg_rdata_out == $past(active_energy))
    else $error("active energy read mismatch");
  reactive_sign_a: assert property (@(posedge clock_in)
    disable iff (!rst_b_in)
    reg_rd_in && reg_addr_in == mcg_pkg::REACTIVE_ENERGY_ADDR |=>
    reg_rdata_out[31] == $past(rea_acc[47]))
    else $error("reactive energy sign bit lost");
  rms_read_a: assert property (@(posedge clock_in)
    disable iff (!rst_b_in)
    reg_rd_in && reg_addr_in == mcg_pkg::CURR_RMS_ADDR |=>
    reg_rdata_out == {8'h00, $past(current_rms_reading_in)})
    else $error("current rms read mismatch");
  rotate_zero_a: assert property (@(posedge clock_in)
    disable iff (!rst_b_in)
    offset_sel == 16'sh0000 |-> p_rot == s2_p && q_rot == s2_q)
    else $error("zero offset rotated power");
  power_unity_a: assert property (@(posedge clock_in)
    disable iff (!rst_b_in)
    s2_valid && power_gain == mcg_pkg::GAIN_UNITY |=>
    act_acc == $past(act_acc) + {{24{$past(p_rot[23])}}, $past(p_rot)})
    else $error("unity power gain altered energy step");

  write_gain_c: cover property (@(posedge clock_in)
    reg_wr_in && reg_addr_in == mcg_pkg::VOLT_GAIN_ADDR);
  second_offset_c: cover property (@(posedge clock_in)
    offset_sel == offset_second && thr_low != mcg_pkg::THR_RST);
  third_offset_c: cover property (@(posedge clock_in)
    offset_sel == offset_third && thr_high != mcg_pkg::THR_RST);
  capacitive_c: cover property (@(posedge clock_in) rea_acc[47]);
endmodule : mcg_cal

// File: design/mcg_pkg.sv
package mcg_pkg;
  // ==========================================================
  // widths
  localparam int SAMPLE_W = 24;
  localparam int GAIN_W = 16;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int ACC_W = 48;
  // ==========================================================
  // fixed-point layout
  localparam int GAIN_FRAC = 14; // 0x4000 is unity
  localparam int ANGLE_FRAC = 16; // radians times 65,536
  localparam int ACC_LSB = 16; // energy word is acc top 32 bits
  localparam int THR_LSB = 8; // rms bits below the threshold lsb
  // ==========================================================
  // reset values
  localparam logic [15:0] GAIN_UNITY = 16'h4000;
  localparam logic [15:0] OFFSET_RST = 16'h0000;
  localparam logic [15:0] THR_RST = 16'h0000;
  // ==========================================================
  // register offsets
  localparam logic [11:0] VOLT_GAIN_ADDR = 12'h100;
  localparam logic [11:0] CURR_GAIN_ADDR = 12'h104;
  localparam logic [11:0] POWER_GAIN_ADDR = 12'h108;
  localparam logic [11:0] OFFSET_FIRST_ADDR = 12'h10c;
  localparam logic [11:0] OFFSET_SECOND_ADDR = 12'h110;
  localparam logic [11:0] OFFSET_THIRD_ADDR = 12'h114;
  localparam logic [11:0] THR_LOW_ADDR = 12'h118;
  localparam logic [11:0] THR_HIGH_ADDR = 12'h11c;
  localparam logic [11:0] VOLT_RMS_ADDR = 12'h1c8;
  localparam logic [11:0] CURR_RMS_ADDR = 12'h1cc;
  localparam logic [11:0] ACTIVE_ENERGY_ADDR = 12'h1d0;
  localparam logic [11:0] REACTIVE_ENERGY_ADDR = 12'h1d4;
endpackage : mcg_pkg

// File: tb/mcg_host_model.sv
module mcg_host_model #(
  parameter int SETTLE_CYC = 20 // stands in for seconds of rms settling
) (
  // clock
  input wire logic clock_in,
  // register port toward the device
  output logic [11:0] reg_addr_out,
  output logic [31:0] reg_wdata_out,
  output logic reg_wr_out,
  output logic reg_rd_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // host side state
  localparam logic [11:0] GADR [0:2] = '{mcg_pkg::VOLT_GAIN_ADDR,
    mcg_pkg::CURR_GAIN_ADDR, mcg_pkg::POWER_GAIN_ADDR};
  logic [15:0] nv_gain [0:2]; // survives device resets
  // idle bus at time zero
  initial begin
    reg_addr_out = 12'h000;
    reg_wdata_out = 32'h0000_0000;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    for (int k = 0; k < 3; k++) nv_gain[k] = mcg_pkg::GAIN_UNITY;
  end
  // ==========================================================
  // bus cycles: held across one rising edge
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(negedge clock_in);
    reg_addr_out = a;
    reg_wdata_out = {16'h0000, d};
    reg_wr_out = 1'b1;
    @(negedge clock_in);
    reg_wr_out = 1'b0;
    reg_wdata_out = ~reg_wdata_out; // no stale data once released
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(negedge clock_in);
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(negedge clock_in);
    reg_rd_out = 1'b0;
  endtask : rd
  // gain from a 2.14 ratio, top bit forced clear
  task automatic cal(input int k, input logic [15:0] ratio);
    nv_gain[k] = ratio & 16'h7fff;
    wr(GADR[k], nv_gain[k]);
  endtask : cal
  // constants rewritten after any device reset
  task automatic reload();
    for (int k = 0; k < 3; k++) wr(GADR[k], nv_gain[k]);
  endtask : reload
  task automatic settle();
    repeat (SETTLE_CYC) @(posedge clock_in);
  endtask : settle
endmodule : mcg_host_model

// File: tb/meter_calibration_gain_phase_tb_top.sv
module meter_calibration_gain_phase_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // signals and scoreboard
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic sample_valid_in = 1'b0;
  logic signed [23:0] volt_sample_in = 24'h000000;
  logic signed [23:0] volt_quad_in = 24'h000000;
  logic signed [23:0] curr_sample_in = 24'h000000;
  logic [23:0] voltage_rms_reading = 24'h000000;
  logic [23:0] current_rms_reading = 24'h000000;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata_out;
  logic reg_rvalid_out;
  logic corr_valid_out;
  logic signed [23:0] corr_volt_out;
  logic signed [23:0] corr_curr_out;
  logic [31:0] rq_exp [$];
  logic [31:0] rq_msk [$];
  logic [47:0] cq [$];
  logic [47:0] c;
  logic [31:0] e;
  logic [31:0] m;
  logic [15:0] vg = 16'h4000;
  logic [15:0] ig = 16'h4000;
  logic [15:0] r;
  int num_errors = 0;
  int check_count = 0;
  always #50 clock_in = ~clock_in;
  mcg_host_model mcg_host_model_i (.clock_in(clock_in),
    .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata),
    .reg_wr_out(reg_wr), .reg_rd_out(reg_rd));
  mcg_cal mcg_cal_i (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .sample_valid_in(sample_valid_in), .volt_sample_in(volt_sample_in),
    .volt_quad_in(volt_quad_in), .curr_sample_in(curr_sample_in),
    .voltage_rms_reading_in(voltage_rms_reading), .current_rms_reading_in(current_rms_reading),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .corr_valid_out(corr_valid_out),
    .corr_volt_out(corr_volt_out), .corr_curr_out(corr_curr_out));
  // ==========================================================
  // helpers
  function automatic logic [23:0] ex(input logic signed [23:0] x,
                                     input logic [15:0] g);
    logic signed [47:0] p;
    p = x * $signed({1'b0, g});
    return p[37:14]; // wraps, no saturation
  endfunction : ex
  task automatic chk(input string nm, input logic [31:0] ev,
                     input logic [31:0] gv);
    check_count++;
    if (gv !== ev) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, ev, gv);
    end
  endtask : chk
  task automatic rdx(input logic [11:0] a, input logic [31:0] ev,
                     input logic [31:0] mv);
    rq_exp.push_back(ev);
    rq_msk.push_back(mv);
    mcg_host_model_i.rd(a);
  endtask : rdx
  task automatic smp(input logic [23:0] v, input logic [23:0] q,
                     input logic [23:0] i);
    cq.push_back({ex(v, vg), ex(i, ig)});
    @(negedge clock_in);
    volt_sample_in = v;
    volt_quad_in = q;
    curr_sample_in = i;
    sample_valid_in = 1'b1;
    @(negedge clock_in);
    sample_valid_in = 1'b0;
  endtask : smp
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  // bounded drain of outstanding notes
  task automatic drain();
    for (int k = 0; k < 200 && (rq_exp.size() + cq.size()) > 0; k++)
      @(posedge clock_in);
    if ((rq_exp.size() + cq.size()) > 0) begin
      num_errors++;
      test_done();
    end
  endtask : drain
  // ==========================================================
  // monitor: oldest note against each result
  always @(posedge clock_in) begin
    if (reg_rvalid_out) begin
      e = rq_exp.pop_front();
      m = rq_msk.pop_front();
      chk("reg_rdata", e & m, reg_rdata_out & m);
    end
    if (corr_valid_out) begin
      c = cq.pop_front();
      chk("corr_volt", {8'h00, c[47:24]}, {8'h00, corr_volt_out});
      chk("corr_curr", {8'h00, c[23:0]}, {8'h00, corr_curr_out});
    end
  end
  // hang guard
  initial begin
    #5000000;
    num_errors++;
    test_done();
  end
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(87));
    voltage_rms_reading = 24'($urandom);
    current_rms_reading = 24'($urandom);
    repeat (16) @(negedge clock_in);
    rst_b_in = 1'b1;
    rdx(mcg_pkg::VOLT_GAIN_ADDR, 32'h0000_4000, '1);
    rdx(mcg_pkg::CURR_GAIN_ADDR, 32'h0000_4000, '1);
    rdx(mcg_pkg::POWER_GAIN_ADDR, 32'h0000_4000, '1);
    for (int k = 0; k < 5; k++)
      rdx(12'(mcg_pkg::OFFSET_FIRST_ADDR + 4 * k), '0, '1);
    rdx(mcg_pkg::ACTIVE_ENERGY_ADDR, '0, '1);
    rdx(mcg_pkg::REACTIVE_ENERGY_ADDR, '0, '1);
    rdx(mcg_pkg::VOLT_RMS_ADDR, {8'h00, voltage_rms_reading}, '1);
    rdx(mcg_pkg::CURR_RMS_ADDR, {8'h00, current_rms_reading}, '1);
    rdx(12'h3f0, '0, '1);
    smp(24'($urandom), 24'($urandom), 24'($urandom));
    r = 16'($urandom);
    mcg_host_model_i.cal(0, r);
    vg = r & 16'h7fff;
    r = 16'($urandom);
    mcg_host_model_i.cal(1, r);
    ig = r & 16'h7fff;
    rdx(mcg_pkg::VOLT_GAIN_ADDR, {16'h0000, vg}, '1);
    for (int k = 0; k < 8; k++)
      smp(24'($urandom), 24'($urandom), 24'($urandom));
    mcg_host_model_i.wr(mcg_pkg::OFFSET_FIRST_ADDR, 16'hfdc4);
    rdx(mcg_pkg::OFFSET_FIRST_ADDR, 32'h0000_fdc4, '1);
    mcg_host_model_i.wr(12'h3f0, 16'hffff);
    rdx(12'h3f0, '0, '1);
    drain();
    // device reset mid-run, host restores its constants
    @(negedge clock_in);
    rst_b_in = 1'b0;
    repeat (2) @(negedge clock_in);
    rst_b_in = 1'b1;
    rdx(mcg_pkg::OFFSET_FIRST_ADDR, '0, '1);
    rdx(mcg_pkg::VOLT_GAIN_ADDR, 32'h0000_4000, '1);
    mcg_host_model_i.reload();
    rdx(mcg_pkg::CURR_GAIN_ADDR, {16'h0000, ig}, '1);
    // zero power gain blocks energy, unity lets signs through
    mcg_host_model_i.cal(0, 16'h4000);
    mcg_host_model_i.cal(1, 16'h4000);
    vg = 16'h4000;
    ig = 16'h4000;
    for (int n = 0; n < 2; n++) begin
      mcg_host_model_i.cal(2, n ? 16'h4000 : 16'h0000);
      for (int k = 0; k < 20; k++)
        smp(24'h400000, 24'hc00000, 24'h400000);
      mcg_host_model_i.settle();
      if (n == 0)
        rdx(mcg_pkg::ACTIVE_ENERGY_ADDR, '0, '1);
    end
    // 20 steps of p = 2^20 and q = -2^20: words of +0x140 and -0x140
    rdx(mcg_pkg::ACTIVE_ENERGY_ADDR, 32'h0000_0140, '1);
    rdx(mcg_pkg::REACTIVE_ENERGY_ADDR, 32'hffff_fec0, '1);
    // thresholds pick the offset by current level
    mcg_host_model_i.wr(mcg_pkg::THR_LOW_ADDR, 16'h0010);
    mcg_host_model_i.wr(mcg_pkg::THR_HIGH_ADDR, 16'h0020);
    mcg_host_model_i.wr(mcg_pkg::OFFSET_THIRD_ADDR, 16'h4000);
    current_rms_reading = 24'h001800; // between thresholds: second offset
    mcg_host_model_i.settle();
    rdx(mcg_pkg::THR_HIGH_ADDR, 32'h0000_0020, '1);
    current_rms_reading = 24'hffffff; // above both: third offset, a quarter radian
    for (int k = 0; k < 16; k++)
      smp(24'h400000, 24'hc00000, 24'h400000);
    mcg_host_model_i.settle();
    // each step p' = p + q/4, q' = q - p/4 on top of the earlier sums
    rdx(mcg_pkg::ACTIVE_ENERGY_ADDR, 32'h0000_0200, '1);
    rdx(mcg_pkg::REACTIVE_ENERGY_ADDR, 32'hffff_fd80, '1);
    // gain with the top bit set still follows the 2.14 shift
    mcg_host_model_i.wr(mcg_pkg::CURR_GAIN_ADDR, 16'h8000);
    ig = 16'h8000;
    smp(24'h000000, 24'h000000, 24'h000100);
    drain();
    test_done();
  end
endmodule : meter_calibration_gain_phase_tb_top
